// ===== src/pmc_pkg.sv
package pmc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [7:0] OFS_DEV_VENDOR_ID = 8'h00;
   localparam logic [7:0] OFS_NV_CTRL       = 8'h48;
   localparam logic [7:0] OFS_CAP_STATUS    = 8'h4c;
   localparam logic [7:0] OFS_POWER_CAP     = 8'hc0;

   ////////////////////////////////////////////////////////////////////////////
   // power capability field positions
   localparam int POS_CAP_ID        = 0;
   localparam int POS_NEXT_ITEM     = 8;
   localparam int POS_SPEC_REV      = 16;
   localparam int POS_WAKE_CLK_DEP  = 19;
   localparam int POS_DEV_INIT      = 21;
   localparam int POS_AUX_CURRENT   = 22;
   localparam int POS_STATE_ONE     = 25;
   localparam int POS_STATE_TWO     = 26;
   localparam int POS_WAKE_D0       = 27;
   localparam int POS_WAKE_D1       = 28;
   localparam int POS_WAKE_D2       = 29;
   localparam int POS_WAKE_D3HOT    = 30;
   localparam int POS_COLD_WAKE     = 31;

   ////////////////////////////////////////////////////////////////////////////
   // fixed field values
   localparam logic [7:0] CAP_ID_PM        = 8'h01;
   localparam logic [7:0] NEXT_ITEM_NONE   = 8'h00;
   localparam logic [2:0] SPEC_REV_1_0A    = 3'h2;
   localparam logic       WAKE_CLK_DEP_NO  = 1'b0;
   localparam logic       DEV_INIT_NONE    = 1'b0;
   localparam logic [2:0] AUX_CUR_375MA    = 3'h7;
   localparam logic [2:0] AUX_CUR_NONE     = 3'h0;
   localparam logic       STATE_SUPPORTED  = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // nonvolatile control register and status register layout
   localparam int         POS_COLD_WAKE_EN_NV = 31;
   localparam int         POS_NV_LOW_HALF     = 16;
   localparam logic [31:0] NV_CTRL_RESET      = 32'h0000_0000;
   localparam int         POS_ST_DONE         = 0;
   localparam int         POS_ST_AUX          = 1;
   localparam int         POS_ST_NV_READY     = 2;
   localparam int         POS_ST_IGN_CNT      = 8;
   localparam int         POS_CMD_RECAPTURE   = 0;
   localparam logic [7:0] IGN_CNT_RESET       = 8'h00;
   localparam logic [31:0] RDATA_RESET        = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } pmc_bus_req_t;

   typedef enum logic [1:0] {
      CAP_SENSE = 2'b00,
      CAP_WAIT  = 2'b01,
      CAP_DONE  = 2'b11
   } pmc_cap_state_t;

endpackage

// ===== src/pmc_strap_capture.sv
`timescale 1ns/10ps
module pmc_strap_capture (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_n,
   // sampling sources
   input  wire logic aux_power_sense,
   input  wire logic nv_ready,
   input  wire logic cold_wake_enable_nv,
   input  wire logic rearm,
   // results
   output logic      cold_off_wake_support,
   output logic      aux_sensed,
   output logic      capture_done
);

   typedef struct packed {
      pmc_pkg::pmc_cap_state_t state;
      logic                    aux_q;
      logic                    cold;
   } pmc_cap_st_t;

   pmc_cap_st_t st_reg;
   pmc_cap_st_t st_next;

   ////////////////////////////////////////////////////////////////////////////
   // the pin is caught on the first edge after release, since an async
   // reset may only load constants
   always_comb begin
      st_next = st_reg;
      case (st_reg.state)
         pmc_pkg::CAP_SENSE: begin
            st_next.aux_q = aux_power_sense;
            st_next.cold  = 1'b0;
            st_next.state = pmc_pkg::CAP_WAIT;
         end
         pmc_pkg::CAP_WAIT: begin
            if (nv_ready) begin
               st_next.cold  = st_reg.aux_q & cold_wake_enable_nv;
               st_next.state = pmc_pkg::CAP_DONE;
            end
         end
         pmc_pkg::CAP_DONE: begin
            if (rearm) begin
               st_next.state = pmc_pkg::CAP_SENSE;
            end
         end
         default: begin
            st_next.state = pmc_pkg::CAP_SENSE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '{state: pmc_pkg::CAP_SENSE, aux_q: 1'b0, cold: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign cold_off_wake_support = st_reg.cold;
   assign aux_sensed            = st_reg.aux_q;
   assign capture_done          = (st_reg.state == pmc_pkg::CAP_DONE);

endmodule // pmc_strap_capture

// ===== src/pmc_read_port.sv
`timescale 1ns/10ps
module pmc_read_port (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // selected word
   input  wire logic        rd,
   input  wire logic        hit,
   input  wire logic [31:0] sel_data,
   // bus answer
   output logic [31:0]      rdata
);

   typedef struct packed {
      logic [31:0] rdata;
   } pmc_rd_st_t;

   pmc_rd_st_t st_reg;
   pmc_rd_st_t st_next;

   ////////////////////////////////////////////////////////////////////////////
   // data stand only in the cycle after the strobe; unmapped reads give zero
   always_comb begin
      st_next = st_reg;
      st_next.rdata = (rd && hit) ? sel_data : pmc_pkg::RDATA_RESET;
   end

   // answer register
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '{rdata: pmc_pkg::RDATA_RESET};
      end else begin
         st_reg <= st_next;
      end
   end

   assign rdata = st_reg.rdata;

endmodule // pmc_read_port

// ===== src/pmc_cap_regs.sv
// Summary of operation
// - next item link reads zero: last entry
// - wake reported from D0 through D3hot; D3cold only with the cold wake bit
// - cold wake bit loaded from nonvolatile memory
// - aux sense low at reset clears cold wake
// - cold wake set only if sense and enable
// - state two support reported read-only
// - state one support reported read-only
// - cold wake one gives aux current 111b
// - cold wake zero gives aux current 000b
// - device specific initialization bit reads zero
// - wake needs no host bus clock
// - spec revision field reads 010b
// - device and vendor identity readable
// - capability identifier always reads one
`timescale 1ns/10ps
module pmc_cap_regs #(
   // identity codes: arbitrary neutral values
   parameter logic [15:0] DEVICE_IDENTITY = 16'h0a5c,
   parameter logic [15:0] VENDOR_IDENTITY = 16'h1f00
) (
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   // register port
   input  wire pmc_pkg::pmc_bus_req_t bus_req,
   output logic [31:0]                reg_rdata,
   // nonvolatile memory load
   input  wire logic [15:0]           nv_ctrl_word,
   input  wire logic                  nv_load,
   // auxiliary power sense pin
   input  wire logic                  aux_power_sense,
   // status towards the rest of the device
   output logic                       cold_off_wake_support,
   output logic [2:0]                 aux_current
);

   ////////////////////////////////////////////////////////////////////////////
   // state of this module

   typedef struct packed {
      logic [31:0] nv_ctrl;
      logic        nv_ready;
      logic [7:0]  ign_cnt;
      logic        recapture;
   } pmc_top_st_t;

   pmc_top_st_t st_reg;
   pmc_top_st_t st_next;

   ////////////////////////////////////////////////////////////////////////////
   // address decode

   logic hit_id;
   logic hit_nv;
   logic hit_st;
   logic hit_cap;
   logic hit_any;

   // one decoder shared by reads and writes
   always_comb begin
      hit_id  = (bus_req.addr == pmc_pkg::OFS_DEV_VENDOR_ID);
      hit_nv  = (bus_req.addr == pmc_pkg::OFS_NV_CTRL);
      hit_st  = (bus_req.addr == pmc_pkg::OFS_CAP_STATUS);
      hit_cap = (bus_req.addr == pmc_pkg::OFS_POWER_CAP);
      hit_any = hit_id | hit_nv | hit_st | hit_cap;
   end

   ////////////////////////////////////////////////////////////////////////////
   // strap capture of the cold wake support bit

   logic cold_bit;
   logic aux_sensed;
   logic capture_done;

   pmc_strap_capture u_capture (
      .clk_sys               (clk_sys),
      .rst_n                 (rst_n),
      .aux_power_sense       (aux_power_sense),
      .nv_ready              (st_reg.nv_ready),
      .cold_wake_enable_nv   (st_reg.nv_ctrl[pmc_pkg::POS_COLD_WAKE_EN_NV]),
      .rearm                 (st_reg.recapture),
      .cold_off_wake_support (cold_bit),
      .aux_sensed            (aux_sensed),
      .capture_done          (capture_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // power capability word, built from constants plus the captured bit

   logic [31:0] cap_word;
   logic [2:0]  aux_cur;

   // aux current follows the cold wake bit
   always_comb begin
      if (cold_bit) begin
         aux_cur = pmc_pkg::AUX_CUR_375MA;
      end else begin
         aux_cur = pmc_pkg::AUX_CUR_NONE;
      end
   end

   // the word has no storage, so no write to its offset can ever alter it
   always_comb begin
      cap_word = 32'h0000_0000;
      cap_word[pmc_pkg::POS_CAP_ID +: 8]    = pmc_pkg::CAP_ID_PM;
      cap_word[pmc_pkg::POS_NEXT_ITEM +: 8] = pmc_pkg::NEXT_ITEM_NONE;
      cap_word[pmc_pkg::POS_SPEC_REV +: 3]  = pmc_pkg::SPEC_REV_1_0A;
      cap_word[pmc_pkg::POS_WAKE_CLK_DEP]   = pmc_pkg::WAKE_CLK_DEP_NO;
      cap_word[pmc_pkg::POS_DEV_INIT]       = pmc_pkg::DEV_INIT_NONE;
      cap_word[pmc_pkg::POS_AUX_CURRENT +: 3] = aux_cur;
      cap_word[pmc_pkg::POS_STATE_ONE]      = pmc_pkg::STATE_SUPPORTED;
      cap_word[pmc_pkg::POS_STATE_TWO]      = pmc_pkg::STATE_SUPPORTED;
      cap_word[pmc_pkg::POS_WAKE_D0]        = pmc_pkg::STATE_SUPPORTED;
      cap_word[pmc_pkg::POS_WAKE_D1]        = pmc_pkg::STATE_SUPPORTED;
      cap_word[pmc_pkg::POS_WAKE_D2]        = pmc_pkg::STATE_SUPPORTED;
      cap_word[pmc_pkg::POS_WAKE_D3HOT]     = pmc_pkg::STATE_SUPPORTED;
      cap_word[pmc_pkg::POS_COLD_WAKE]      = cold_bit;
   end

   ////////////////////////////////////////////////////////////////////////////
   // identity and status words

   logic [31:0] id_word;
   logic [31:0] st_word;

   // identity is fixed at build time
   always_comb begin
      id_word = {DEVICE_IDENTITY, VENDOR_IDENTITY};
   end

   // status shows the capture progress and the refused writes
   always_comb begin
      st_word = 32'h0000_0000;
      st_word[pmc_pkg::POS_ST_DONE]        = capture_done;
      st_word[pmc_pkg::POS_ST_AUX]         = aux_sensed;
      st_word[pmc_pkg::POS_ST_NV_READY]    = st_reg.nv_ready;
      st_word[pmc_pkg::POS_ST_IGN_CNT +: 8] = st_reg.ign_cnt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // read select

   logic [31:0] sel_data;

   // a priority chain is enough; the hits are exclusive
   always_comb begin
      if (hit_cap) begin
         sel_data = cap_word;
      end else if (hit_id) begin
         sel_data = id_word;
      end else if (hit_nv) begin
         sel_data = st_reg.nv_ctrl;
      end else if (hit_st) begin
         sel_data = st_word;
      end else begin
         sel_data = 32'h0000_0000;
      end
   end

   pmc_read_port u_read (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .rd       (bus_req.rd),
      .hit      (hit_any),
      .sel_data (sel_data),
      .rdata    (reg_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // writes and nonvolatile load

   logic wr_nv;
   logic wr_st;
   logic wr_ro;

   // writes to the read-only words only bump a counter
   always_comb begin
      wr_nv = bus_req.wr & hit_nv;
      wr_st = bus_req.wr & hit_st;
      wr_ro = bus_req.wr & (hit_cap | hit_id);
   end

   // the nonvolatile load wins bits 31:16 over a software write in the same cycle,
   // so after such a cycle the stored enable matches what the memory delivered
   always_comb begin
      st_next = st_reg;
      st_next.recapture = 1'b0;
      if (wr_nv) begin
         st_next.nv_ctrl = bus_req.wdata;
      end
      if (nv_load) begin
         st_next.nv_ctrl[pmc_pkg::POS_NV_LOW_HALF +: 16] = nv_ctrl_word;
         st_next.nv_ready = 1'b1;
      end
      if (wr_st) begin
         st_next.recapture = bus_req.wdata[pmc_pkg::POS_CMD_RECAPTURE];
      end
      if (wr_ro && (st_reg.ign_cnt != 8'hff)) begin
         st_next.ign_cnt = st_reg.ign_cnt + 8'h01;           // saturates, never wraps
      end
   end

   // state register
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '{nv_ctrl:   pmc_pkg::NV_CTRL_RESET,
                     nv_ready:  1'b0,
                     ign_cnt:   pmc_pkg::IGN_CNT_RESET,
                     recapture: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign cold_off_wake_support = cold_bit;
   assign aux_current           = aux_cur;

endmodule // pmc_cap_regs

// ===== sim/pmc_cap_monitor.sv
`timescale 1ns/10ps
module pmc_cap_monitor #(
   parameter logic [15:0] DEVICE_IDENTITY = 16'h0a5c,
   parameter logic [15:0] VENDOR_IDENTITY = 16'h1f00
) (
   // clock and reset
   input wire logic                  clk_sys,
   input wire logic                  rst_n,
   // register port
   input wire pmc_pkg::pmc_bus_req_t bus_req,
   input wire logic [31:0]           reg_rdata,
   // load and pin
   input wire logic [15:0]           nv_ctrl_word,
   input wire logic                  nv_load,
   input wire logic                  aux_power_sense,
   // status
   input wire logic                  cold_off_wake_support,
   input wire logic [2:0]            aux_current
);
   logic armed_reg;
   logic aux_seen_reg;
   logic cap_rd;
   // pin level as the block sees it at the first edge after release
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         armed_reg    <= 1'b1;
         aux_seen_reg <= 1'b0;
      end else if (armed_reg) begin
         armed_reg    <= 1'b0;
         aux_seen_reg <= aux_power_sense;
      end
   end
   assign cap_rd = bus_req.rd && bus_req.addr == pmc_pkg::OFS_POWER_CAP;
   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // fields of the capability word, identity word and idle read data
   head_a: assert property (cap_rd |=> reg_rdata[15:0] == 16'h0001)
      else $error("capability head wrong");
   fixed_bits_a: assert property (cap_rd |=> reg_rdata[21:16] == 6'h02)
      else $error("revision or flag bits wrong");
   wake_states_a: assert property (cap_rd |=> reg_rdata[30:25] == 6'h3f)
      else $error("state support bits wrong");
   cold_read_a: assert property (cap_rd
      |=> reg_rdata[31] == $past(cold_off_wake_support))
      else $error("cold wake bit not reported");
   aux_field_a: assert property (aux_current == {3{cold_off_wake_support}})
      else $error("aux current field wrong");
   identity_a: assert property (bus_req.rd
      && bus_req.addr == pmc_pkg::OFS_DEV_VENDOR_ID
      |=> reg_rdata == {DEVICE_IDENTITY, VENDOR_IDENTITY})
      else $error("identity word wrong");
   idle_zero_a: assert property (!bus_req.rd |=> reg_rdata == 32'h0000_0000)
      else $error("read data outside its cycle");
   // cold wake support follows pin and stored enable
   cold_aux_a: assert property (cold_off_wake_support |-> aux_seen_reg)
      else $error("cold wake set with pin low");
   cold_load_a: assert property (nv_load && nv_ctrl_word[15]
      && aux_power_sense |-> ##[1:4] cold_off_wake_support)
      else $error("cold wake not loaded");
   cold_off_a: assert property (nv_load && !nv_ctrl_word[15]
      |=> (!cold_off_wake_support) [*4])
      else $error("cold wake set without enable");
endmodule // pmc_cap_monitor

bind pmc_cap_regs pmc_cap_monitor #(
   .DEVICE_IDENTITY(DEVICE_IDENTITY),
   .VENDOR_IDENTITY(VENDOR_IDENTITY)
) pmc_cap_monitor_i (
   .clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .reg_rdata(reg_rdata),
   .nv_ctrl_word(nv_ctrl_word), .nv_load(nv_load), .aux_power_sense(aux_power_sense),
   .cold_off_wake_support(cold_off_wake_support), .aux_current(aux_current)
);

// ===== sim/pmc_nv_model.sv
`timescale 1ns/10ps
module pmc_nv_model (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   // stored enable and recall time
   input  wire logic       cold_enable,
   input  wire logic [3:0] delay,
   // recall towards the block
   output logic            nv_load,
   output logic [15:0]     nv_ctrl_word
);
   logic [4:0] cnt;
   // one recall per reset; the word toggles outside the pulse so stale data shows
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt          <= 5'h00;
         nv_load      <= 1'b0;
         nv_ctrl_word <= 16'h5a5a;
      end else if (cnt == {1'b0, delay} + 5'h01) begin
         cnt          <= cnt + 5'h01;
         nv_load      <= 1'b1;
         nv_ctrl_word <= {cold_enable, 15'h1234};
      end else begin
         nv_load      <= 1'b0;
         nv_ctrl_word <= ~nv_ctrl_word;
         if (cnt <= {1'b0, delay}) begin
            cnt <= cnt + 5'h01;
         end
      end
   end
endmodule // pmc_nv_model

// ===== sim/test_pmc_cap_regs.sv
`timescale 1ns/10ps
module test_pmc_cap_regs;
   // identity codes: arbitrary values
   localparam logic [15:0] DEV_ID = 16'h3c5a;
   localparam logic [15:0] VEN_ID = 16'h0f1e;
   logic                  clk_sys = 1'b0;
   logic                  rst_n = 1'b0;
   pmc_pkg::pmc_bus_req_t bus_req = '0;
   logic [31:0]           reg_rdata;
   logic [15:0]           nv_ctrl_word;
   logic                  nv_load;
   logic                  aux_power_sense = 1'b0;
   logic                  cold_off_wake_support;
   logic [2:0]            aux_current;
   logic                  cold_enable = 1'b0;
   logic [3:0]            delay = 4'h1;
   logic [31:0]           rd_val;
   logic                  c;
   logic                  v;
   int                    mismatches = 0;
   int                    samples_checked = 0;

   always #5 clk_sys = ~clk_sys;

   pmc_cap_regs #(.DEVICE_IDENTITY(DEV_ID), .VENDOR_IDENTITY(VEN_ID)) pmc_cap_regs_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .reg_rdata(reg_rdata),
      .nv_ctrl_word(nv_ctrl_word), .nv_load(nv_load), .aux_power_sense(aux_power_sense),
      .cold_off_wake_support(cold_off_wake_support), .aux_current(aux_current));
   pmc_nv_model pmc_nv_model_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .cold_enable(cold_enable), .delay(delay),
      .nv_load(nv_load), .nv_ctrl_word(nv_ctrl_word));
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   // read data is taken one edge after the strobe, the only cycle it stands
   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus_req.rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus_req.wr <= 1'b0;
   endtask
   function automatic logic [31:0] exp_cap(input logic cw);
      return {cw, 4'hf, 2'b11, {3{cw}}, 3'b000, 3'b010, 8'h00, 8'h01};
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   // three setups: pin and enable high, pin low, enable low; recall delay 1, 7 then 13
   initial begin
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_sys);
         rst_n           <= 1'b0;
         aux_power_sense <= (i != 1);
         cold_enable     <= (i != 2);
         delay           <= 4'(i * 6 + 1);
         repeat (8) @(posedge clk_sys);
         rst_n <= 1'b1;
         c = (i == 0);
         for (int k = 0; k < 40 && nv_load !== 1'b1; k++) @(posedge clk_sys);
         repeat (4) @(posedge clk_sys);
         bus_rd(pmc_pkg::OFS_POWER_CAP, rd_val);
         check("cap word", exp_cap(c), rd_val);
         check("aux current", {29'h0, {3{c}}}, {29'h0, aux_current});
         check("cold wake", {31'h0, c}, {31'h0, cold_off_wake_support});
         bus_wr(pmc_pkg::OFS_POWER_CAP, 32'hffff_ffff);
         bus_wr(pmc_pkg::OFS_DEV_VENDOR_ID, 32'h0000_0000);
         bus_rd(pmc_pkg::OFS_POWER_CAP, rd_val);
         check("cap after write", exp_cap(c), rd_val);
         bus_rd(pmc_pkg::OFS_DEV_VENDOR_ID, rd_val);
         check("identity", {DEV_ID, VEN_ID}, rd_val);
         bus_rd(8'h80, rd_val);
         check("unmapped", 32'h0000_0000, rd_val);
         bus_rd(pmc_pkg::OFS_CAP_STATUS, rd_val);
         check("status", {16'h0, 8'h02, 5'h0, 1'b1, i != 1, 1'b1}, {16'h0, rd_val[15:0]});
         // rewrite the stored enable and rerun the capture: only the third setup
         // has the pin high with the enable set, so only it may report cold wake
         v = (i == 2);
         bus_wr(pmc_pkg::OFS_NV_CTRL, {v, 31'h0000_0000});
         bus_rd(pmc_pkg::OFS_NV_CTRL, rd_val);
         check("nv control", {v, 31'h0000_0000}, rd_val);
         bus_wr(pmc_pkg::OFS_CAP_STATUS, 32'h0000_0001);
         repeat (4) @(posedge clk_sys);
         bus_rd(pmc_pkg::OFS_POWER_CAP, rd_val);
         check("cap after recapture", exp_cap(v), rd_val);
         check("cold after recapture", {31'h0, v}, {31'h0, cold_off_wake_support});
      end
      end_sim;
   end
   // a hang is cut short well past the roughly 150 cycles the tests need
   initial begin
      #100000;
      mismatches++;
      end_sim;
   end
endmodule // test_pmc_cap_regs
